// File: sarbr_top.v
// What this block does
// - first byte read carries result bits 9..2 on data lines 7..0
// - second byte: bits 1,0 on lines 7,6; lower six lines zero
// - conversion lasts 80 to 90 conversion-clock periods from the start request
// - start request latched; sequence starts within 8 periods at phase alignment
// - start and chip select both low hold converter in reset; run after release
// - done flag looped to start with chip select low converts continuously until the 16-word buffer fills
// - inverting input at or above non-inverting input yields all-zero code
// - done flag returns high within 450 ns of start or read strobe falling
// - data valid within 300 ns of read falling; released within 200 ns of rising
// - chip select and read low clear done flag and enable data drivers
// - MSB first, ten comparisons in 80 periods, then latch and drop done flag
// - new start during a conversion aborts it and restarts
`include "sarbr_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module sarbr_top (
    // clock and reset
    input wire i_clk,
    input wire i_reset,
    // host bus strobes, active low, asynchronous
    input wire i_cs_n,
    input wire i_wr_n,
    input wire i_rd_n,
    // comparator: high when the analog difference reaches or exceeds the trial tap
    input wire i_cmp_above,
    // ladder tap code from the approximation register
    output reg [`SARBR_RES_BITS-1:0] o_approx,
    // end-of-conversion flag, active low
    output reg o_done_flag_n,
    // byte-wide data bus: out value and output enable
    output reg [7:0] o_data,
    output reg o_data_oe
);
    localparam integer DIVN = `SARBR_CONV_DIV;
    localparam [5:0] DIV_LAST = DIVN[5:0] - 6'h01;

    // pin synchronisers: three flops per lane, accept once flops 2 and 3 agree
    reg [3:0] sync1_ff;
    reg [3:0] sync2_ff;
    reg [3:0] sync3_ff;
    reg [3:0] lvl_ff;
    wire [3:0] pin_raw;
    wire [3:0] lvl;

    assign pin_raw = {i_cmp_above, i_rd_n, i_wr_n, i_cs_n};

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_sync
            assign lvl[g] = (sync2_ff[g] == sync3_ff[g]) ? sync3_ff[g] : lvl_ff[g];
        end
    endgenerate

    always @(posedge i_clk) begin
        if (i_reset) begin
            sync1_ff <= 4'hF;
            sync2_ff <= 4'hF;
            sync3_ff <= 4'hF;
            lvl_ff <= 4'h7;
        end else begin
            sync1_ff <= pin_raw;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            lvl_ff <= lvl;
        end
    end

    wire start_req = ~lvl[`SARBR_LN_CS] & ~lvl[`SARBR_LN_WR];
    wire start_fall = start_req & ~(~lvl_ff[`SARBR_LN_CS] & ~lvl_ff[`SARBR_LN_WR]);
    wire read_act = ~lvl[`SARBR_LN_CS] & ~lvl[`SARBR_LN_RD];
    wire read_prev = ~lvl_ff[`SARBR_LN_CS] & ~lvl_ff[`SARBR_LN_RD];
    wire read_fall = read_act & ~read_prev;
    wire read_rise = ~read_act & read_prev;

    // conversion clock as an enable pulse
    reg [5:0] div_cnt_ff;
    reg ce_ff;
    always @(posedge i_clk) begin
        if (i_reset) begin
            div_cnt_ff <= 6'h00;
            ce_ff <= 1'b0;
        end else begin
            ce_ff <= (div_cnt_ff == DIV_LAST);
            div_cnt_ff <= (div_cnt_ff == DIV_LAST) ? 6'h00 : div_cnt_ff + 6'h01;
        end
    end

    // free-running internal phase; a latched start waits for a conversion tick in the last phase (SARBR_PHASE_LAST)
    reg [2:0] phase_ff;
    always @(posedge i_clk) begin
        if (i_reset) begin
            phase_ff <= 3'h0;
        end else if (ce_ff) begin
            phase_ff <= phase_ff + 3'h1;
        end
    end

    // sequencer
    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg [3:0] bit_ff;
    reg [3:0] nxt_bit;
    reg [2:0] tick_ff;
    reg [2:0] nxt_tick;
    reg [`SARBR_RES_BITS-1:0] nxt_approx;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [`SARBR_RES_BITS-1:0] fifo_out_data;
    wire push = (state_ff == `SARBR_ST_XFER) & fifo_in_ready;

    always @* begin
        nxt_state = state_ff;
        nxt_bit = bit_ff;
        nxt_tick = tick_ff;
        nxt_approx = o_approx;
        case (state_ff)
            `SARBR_ST_IDLE: begin
                nxt_state = state_ff;
            end
            `SARBR_ST_HOLD: begin
                // held in reset as long as both strobes stay low
                if (!start_req) begin
                    nxt_state = `SARBR_ST_ALIGN;
                end
            end
            `SARBR_ST_ALIGN: begin
                if (ce_ff && phase_ff == `SARBR_PHASE_LAST) begin
                    nxt_state = `SARBR_ST_CONV;
                    nxt_bit = `SARBR_MSB_IDX;
                    nxt_tick = 3'h0;
                end
            end
            `SARBR_ST_CONV: begin
                if (ce_ff) begin
                    nxt_tick = tick_ff + 3'h1;
                    if (tick_ff == 3'h0) begin
                        nxt_approx[bit_ff] = 1'b1;
                    end
                    if (tick_ff == `SARBR_TICKS_PER_BIT) begin
                        // comparator low (difference below the trial tap) drops the trial bit
                        nxt_approx[bit_ff] = lvl[`SARBR_LN_CMP];
                        if (bit_ff == 4'h0) begin
                            nxt_state = `SARBR_ST_XFER;
                        end else begin
                            nxt_bit = bit_ff - 4'h1;
                        end
                    end
                end
            end
            `SARBR_ST_XFER: begin
                // a full buffer stalls here until the host drains a word
                if (fifo_in_ready) begin
                    nxt_state = `SARBR_ST_IDLE;
                end
            end
            default: begin
                nxt_state = `SARBR_ST_IDLE;
            end
        endcase
        if (start_req) begin
            nxt_state = `SARBR_ST_HOLD;
            nxt_approx = {`SARBR_RES_BITS{1'b0}};
            nxt_bit = `SARBR_MSB_IDX;
            nxt_tick = 3'h0;
        end
    end

    always @(posedge i_clk) begin
        if (i_reset) begin
            state_ff <= `SARBR_ST_IDLE;
            bit_ff <= `SARBR_MSB_IDX;
            tick_ff <= 3'h0;
            o_approx <= {`SARBR_RES_BITS{1'b0}};
        end else begin
            state_ff <= nxt_state;
            bit_ff <= nxt_bit;
            tick_ff <= nxt_tick;
            o_approx <= nxt_approx;
        end
    end

    // result buffer between converter and host readout
    wire pop;
    sarbr_fifo #(
        .WIDTH(`SARBR_RES_BITS),
        .DEPTH(`SARBR_FIFO_DEPTH),
        .AW(`SARBR_FIFO_AW)
    ) u_fifo (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_in_valid(state_ff == `SARBR_ST_XFER),
        .i_in_data(o_approx),
        .o_in_ready(fifo_in_ready),
        .o_out_valid(fifo_out_valid),
        .o_out_data(fifo_out_data),
        .i_out_ready(pop)
    );

    // done flag: completion sets it low and wins over a same-cycle clear
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_done_flag_n <= 1'b1;
        end else if (push) begin
            o_done_flag_n <= 1'b0;
        end else if (start_fall || read_fall) begin
            o_done_flag_n <= 1'b1;
        end
    end

    // readout: high byte first, pop the word after its low byte is read
    reg low_sel_ff;
    assign pop = read_rise & low_sel_ff & fifo_out_valid;

    always @(posedge i_clk) begin
        if (i_reset) begin
            low_sel_ff <= 1'b0;
            o_data <= 8'h00;
            o_data_oe <= 1'b0;
        end else begin
            o_data_oe <= read_act;
            if (start_fall) begin
                low_sel_ff <= 1'b0;
            end else if (read_rise) begin
                low_sel_ff <= ~low_sel_ff;
            end
            if (read_fall) begin
                if (!fifo_out_valid) begin
                    o_data <= 8'h00;
                end else if (!low_sel_ff) begin
                    o_data <= fifo_out_data[9:2];
                end else begin
                    o_data <= {fifo_out_data[1:0], 6'h00};
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: sarbr_defines.vh
`ifndef SARBR_DEFINES_VH
`define SARBR_DEFINES_VH

// system clock and conversion clock rates
`define SARBR_CLK_HZ 20000000
`define SARBR_CONV_HZ 410000
// system clocks per conversion-clock period, rounded down (slightly fast, still in range)
`define SARBR_CONV_DIV (`SARBR_CLK_HZ / `SARBR_CONV_HZ)

// conversion geometry
`define SARBR_RES_BITS 10
`define SARBR_TICKS_PER_BIT 3'h7
`define SARBR_PHASE_LAST 3'h7
`define SARBR_MSB_IDX 4'h9

// sequencer states
`define SARBR_ST_IDLE 3'h0
`define SARBR_ST_HOLD 3'h1
`define SARBR_ST_ALIGN 3'h2
`define SARBR_ST_CONV 3'h3
`define SARBR_ST_XFER 3'h4

// result buffer
`define SARBR_FIFO_DEPTH 16
`define SARBR_FIFO_AW 4

// pin sync lane positions
`define SARBR_LN_CS 0
`define SARBR_LN_WR 1
`define SARBR_LN_RD 2
`define SARBR_LN_CMP 3

`endif

// File: sarbr_fifo.v
`timescale 1ns/100ps
`default_nettype none
module sarbr_fifo #(
    parameter WIDTH = 10,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // clock and reset
    input wire i_clk,
    input wire i_reset,
    // fill side
    input wire i_in_valid,
    input wire [WIDTH-1:0] i_in_data,
    output wire o_in_ready,
    // drain side
    output wire o_out_valid,
    output wire [WIDTH-1:0] o_out_data,
    input wire i_out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_ff;
    reg [AW-1:0] rd_ptr_ff;
    reg [AW:0] count_ff;
    wire push;
    wire pop;

    assign o_in_ready = (count_ff != DEPTH[AW:0]);
    assign o_out_valid = (count_ff != {(AW+1){1'b0}});
    assign o_out_data = mem[rd_ptr_ff];
    assign push = i_in_valid & o_in_ready;
    assign pop = i_out_ready & o_out_valid;

    always @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= i_in_data;
        end
    end

    always @(posedge i_clk) begin
        if (i_reset) begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            count_ff <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            if (push & ~pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop & ~push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: sarbr_analog_model.sv
`timescale 1ns/100ps
`default_nettype none
module sarbr_analog_model (
    // analog inputs as codes
    input wire logic [9:0] i_vin_pos,
    input wire logic [9:0] i_vin_neg,
    // trial tap and decision
    input wire logic [9:0] i_approx,
    output logic o_cmp_above
);
    // a negative difference never clears a tap, so the search settles at zero
    assign o_cmp_above = (i_vin_pos > i_vin_neg) && (i_vin_pos - i_vin_neg >= i_approx);
endmodule
`default_nettype wire

// File: sarbr_checker.sv
`timescale 1ns/100ps
`default_nettype none
module sarbr_checker (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // host strobes
    input wire logic i_cs_n,
    input wire logic i_wr_n,
    input wire logic i_rd_n,
    // outputs
    input wire logic [9:0] o_approx,
    input wire logic o_done_flag_n,
    input wire logic o_data_oe
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    logic [12:0] since_start_ff;
    // saturates so a stalled buffer cannot wrap it
    always @(posedge i_clk) begin
        if (i_reset || (!i_cs_n && !i_wr_n)) since_start_ff <= 13'h0000;
        else if (since_start_ff != 13'h1FFF) since_start_ff <= since_start_ff + 13'h0001;
    end
    property p_start_clear;
        (!i_cs_n && !i_wr_n) [*4] |=> o_done_flag_n;
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("start left done flag low");
    property p_hold_reset;
        (!i_cs_n && !i_wr_n) [*5] |=> o_approx == 10'h000;
    endproperty
    a_hold_reset: assert property (p_hold_reset) else $error("converter ran during held start");
    property p_read_en;
        (!i_cs_n && !i_rd_n) [*4] |=> o_data_oe && o_done_flag_n;
    endproperty
    a_read_en: assert property (p_read_en) else $error("read did not drive bus");
    property p_release;
        i_rd_n [*4] |=> !o_data_oe;
    endproperty
    a_release: assert property (p_release) else $error("bus not released after read");
    property p_oe_cause;
        $rose(o_data_oe) |-> !$past(i_cs_n, 3) && !$past(i_rd_n, 3);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("bus driven without read");
    property p_done_time;
        $fell(o_done_flag_n) |-> since_start_ff >= 13'h0F00;
    endproperty
    a_done_time: assert property (p_done_time) else $error("conversion too short");
    property p_done_rise;
        $rose(o_done_flag_n) |-> !$past(i_cs_n, 3) && (!$past(i_wr_n, 3) || !$past(i_rd_n, 3));
    endproperty
    a_done_rise: assert property (p_done_rise) else $error("done flag cleared without strobe");
    property p_start_wait;
        (!i_cs_n && !i_wr_n) ##1 i_wr_n |-> (o_approx == 10'h000) [*8];
    endproperty
    a_start_wait: assert property (p_start_wait) else $error("search began before alignment");
    property p_done_stands;
        (i_wr_n && i_rd_n) [*4] ##0 !o_done_flag_n |=> !o_done_flag_n;
    endproperty
    a_done_stands: assert property (p_done_stands) else $error("done flag dropped on its own");
endmodule
bind sarbr_top sarbr_checker sarbr_checker_i (.i_clk, .i_reset, .i_cs_n, .i_wr_n, .i_rd_n,
    .o_approx, .o_done_flag_n, .o_data_oe);
`default_nettype wire

// File: sar_adc_start_and_byte_readout_test.sv
`timescale 1ns/100ps
`default_nettype none
module sar_adc_start_and_byte_readout_test;
    logic i_clk, i_reset, i_cs_n, i_wr_n, i_rd_n, loop_on;
    logic [9:0] vin_pos, vin_neg;
    wire cmp, done_n, data_oe;
    wire [9:0] approx;
    wire [7:0] data;
    int miscompares, n_compared, cycles;
    sarbr_top sarbr_top_i (.i_clk(i_clk), .i_reset(i_reset), .i_cs_n(i_cs_n), .i_wr_n(i_wr_n),
        .i_rd_n(i_rd_n), .i_cmp_above(cmp), .o_approx(approx), .o_done_flag_n(done_n),
        .o_data(data), .o_data_oe(data_oe));
    sarbr_analog_model sarbr_analog_model_i (.i_vin_pos(vin_pos), .i_vin_neg(vin_neg),
        .i_approx(approx), .o_cmp_above(cmp));
    initial begin
        i_clk = 1'b0;
        // 50 ns period gives a 416.7 kHz conversion enable, one clock wide in every 48
        forever #25 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        // worst-case alignment on every conversion needs about 89000 cycles
        if (cycles == 99000) begin
            miscompares++;
            stop_test();
        end
    end
    // free-running loop: done flag fed back to start
    always @(posedge i_clk) if (loop_on) i_wr_n <= done_n;
    task tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task start(input int hold);
        i_cs_n <= 1'b0;
        tick(1);
        i_wr_n <= 1'b0;
        tick(hold);
        i_wr_n <= 1'b1;
        tick(1);
        i_cs_n <= 1'b1;
    endtask
    task falls(input int want, input int lim, output int n, output int t);
        logic prev;
        n = 0;
        t = 0;
        prev = done_n;
        while (n < want && t < lim) begin
            tick(1);
            t++;
            if (prev === 1'b1 && done_n === 1'b0) n++;
            prev = done_n;
        end
    endtask
    task rd_byte(output logic [7:0] b);
        i_cs_n <= 1'b0;
        tick(1);
        i_rd_n <= 1'b0;
        tick(6);
        b = data;
        check(data_oe, 1'b1);
        check(done_n, 1'b1);
        i_rd_n <= 1'b1;
        tick(5);
        check(data_oe, 1'b0);
        i_cs_n <= 1'b1;
        tick(4);
    endtask
    task rd_word(input logic [9:0] w);
        logic [7:0] b;
        rd_byte(b);
        check(b, w[9:2]);
        rd_byte(b);
        check(b, {w[1:0], 6'h00});
    endtask
    task t_convert(input logic [9:0] pos, input logic [9:0] neg, input logic [9:0] exp);
        int n, t;
        vin_pos <= pos;
        vin_neg <= neg;
        start(4);
        falls(1, 5000, n, t);
        check(t >= 3840 && t <= 4320, 1'b1);
        tick(12);
        rd_word(exp);
        $display("test convert %h done", exp);
    endtask
    task t_abort;
        int n, t;
        logic [7:0] b;
        vin_pos <= 10'h1C3;
        vin_neg <= 10'h000;
        start(4);
        tick(2000);
        i_cs_n <= 1'b0;
        tick(1);
        i_wr_n <= 1'b0;
        tick(400);
        check(approx, 10'h000);
        check(done_n, 1'b1);
        i_wr_n <= 1'b1;
        tick(1);
        i_cs_n <= 1'b1;
        falls(1, 5000, n, t);
        check(t >= 3840 && t <= 4320, 1'b1);
        tick(12);
        rd_word(10'h1C3);
        rd_byte(b);
        check(b, 8'h00);
        $display("test abort done");
    endtask
    task t_free;
        int n, t;
        logic [7:0] b;
        vin_pos <= 10'h15A;
        i_cs_n <= 1'b0;
        tick(1);
        i_wr_n <= 1'b0;
        tick(4);
        i_wr_n <= 1'b1;
        tick(1);
        loop_on <= 1'b1;
        falls(16, 70400, n, t);
        check(n, 16);
        // a full buffer must hold the next result back
        falls(1, 5000, n, t);
        check(n, 0);
        loop_on <= 1'b0;
        tick(1);
        i_wr_n <= 1'b1;
        tick(1);
        i_cs_n <= 1'b1;
        tick(1);
        repeat (17) rd_word(10'h15A);
        rd_byte(b);
        check(b, 8'h00);
        $display("test free run done");
    endtask
    initial begin
        i_reset = 1'b1;
        i_cs_n = 1'b1;
        i_wr_n = 1'b1;
        i_rd_n = 1'b1;
        loop_on = 1'b0;
        vin_pos = 10'h000;
        vin_neg = 10'h000;
        miscompares = 0;
        n_compared = 0;
        cycles = 0;
        tick(4);
        i_reset <= 1'b0;
        tick(2);
        t_convert(10'h2A5, 10'h000, 10'h2A5);
        t_convert(10'h100, 10'h200, 10'h000);
        t_abort();
        t_free();
        stop_test();
    end
endmodule
`default_nettype wire
